// ---- line_ctrl_pkg.sv ----
`default_nettype none
package line_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned LINES = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_LINE_OWNERSHIP_TAKE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LINE_RELEASE_TO_PERIPHERAL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LINE_OWNERSHIP_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_OUTPUT_DRIVER_ENABLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_OUTPUT_DRIVER_DISABLE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_OUTPUT_DRIVER_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_GLITCH_FILTER_ENABLE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_GLITCH_FILTER_DISABLE = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_GLITCH_FILTER_STATUS = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_DRIVE_VALUE_SET = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_DRIVE_VALUE_CLEAR = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_DRIVE_VALUE_STATUS = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_DIRECT_WRITE_MASK_ENABLE = 8'hA0;
  localparam logic [ADDR_W-1:0] OFF_DIRECT_WRITE_MASK_DISABLE = 8'hA4;
  localparam logic [ADDR_W-1:0] OFF_DIRECT_WRITE_MASK_STATUS = 8'hA8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and defaults
  localparam logic [DATA_W-1:0] RST_OWNERSHIP = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] RST_OUT_EN = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_FILT_EN = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_VALUE = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_WMASK = 32'h00000000;
  localparam logic [DATA_W-1:0] ALL_LINES = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [DATA_W-1:0] owned;
    logic [DATA_W-1:0] out_en;
    logic [DATA_W-1:0] filt_en;
    logic [DATA_W-1:0] value;
  } line_cfg_s;

  typedef enum {
    BUS_IDLE,
    BUS_DONE
  } bus_state_e;

endpackage
`default_nettype wire

// ---- line_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

module line_ctrl #(
  parameter logic [31:0] LINE_MASK = 32'hFFFFFFFF,
  parameter logic [31:0] MUXED_MASK = 32'hFFFFFFFF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [line_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [line_ctrl_pkg::DATA_W-1:0] pwdata,
  output logic [line_ctrl_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line configuration towards pads and peripheral mux
  output line_ctrl_pkg::line_cfg_s line_cfg
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus state
  line_ctrl_pkg::bus_state_e state_reg;
  line_ctrl_pkg::bus_state_e state_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [line_ctrl_pkg::DATA_W-1:0] prdata_reg;
  logic [line_ctrl_pkg::DATA_W-1:0] prdata_next;

  ////////////////////////////////////////////////////////////////////////////
  // Line state
  line_ctrl_pkg::line_cfg_s cfg_reg;
  line_ctrl_pkg::line_cfg_s cfg_next;
  logic [line_ctrl_pkg::DATA_W-1:0] wmask_reg;
  logic [line_ctrl_pkg::DATA_W-1:0] wmask_next;

  logic access;
  logic wr_go;
  logic addr_hit;
  logic [line_ctrl_pkg::DATA_W-1:0] wdata_lines;
  logic [line_ctrl_pkg::DATA_W-1:0] rd_word;

  assign access = psel && penable;
  // Write commits at the edge where the master samples pready high
  assign wr_go = (state_reg == line_ctrl_pkg::BUS_DONE) && access && pwrite;
  // Undefined lines never see a write
  assign wdata_lines = pwdata & LINE_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and read mux
  always_comb begin
    addr_hit = 1'b1;
    rd_word = line_ctrl_pkg::ZERO_WORD;
    if (paddr[1:0] != 2'h0) begin
      addr_hit = 1'b0;
    end else begin
      unique case (paddr)
        line_ctrl_pkg::OFF_LINE_OWNERSHIP_TAKE,
        line_ctrl_pkg::OFF_LINE_RELEASE_TO_PERIPHERAL,
        line_ctrl_pkg::OFF_OUTPUT_DRIVER_ENABLE,
        line_ctrl_pkg::OFF_OUTPUT_DRIVER_DISABLE,
        line_ctrl_pkg::OFF_GLITCH_FILTER_ENABLE,
        line_ctrl_pkg::OFF_GLITCH_FILTER_DISABLE,
        line_ctrl_pkg::OFF_DRIVE_VALUE_SET,
        line_ctrl_pkg::OFF_DRIVE_VALUE_CLEAR,
        line_ctrl_pkg::OFF_DIRECT_WRITE_MASK_ENABLE,
        line_ctrl_pkg::OFF_DIRECT_WRITE_MASK_DISABLE: begin
          rd_word = line_ctrl_pkg::ZERO_WORD;
        end
        line_ctrl_pkg::OFF_LINE_OWNERSHIP_STATUS: begin
          rd_word = cfg_reg.owned & LINE_MASK;
        end
        line_ctrl_pkg::OFF_OUTPUT_DRIVER_STATUS: begin
          rd_word = cfg_reg.out_en & LINE_MASK;
        end
        line_ctrl_pkg::OFF_GLITCH_FILTER_STATUS: begin
          rd_word = cfg_reg.filt_en & LINE_MASK;
        end
        line_ctrl_pkg::OFF_DRIVE_VALUE_STATUS: begin
          rd_word = cfg_reg.value & LINE_MASK;
        end
        line_ctrl_pkg::OFF_DIRECT_WRITE_MASK_STATUS: begin
          rd_word = wmask_reg & LINE_MASK;
        end
        default: begin
          addr_hit = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, answer registered
  always_comb begin
    state_next = state_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    unique case (state_reg)
      line_ctrl_pkg::BUS_IDLE: begin
        if (access) begin
          state_next = line_ctrl_pkg::BUS_DONE;
          pready_next = 1'b1;
          pslverr_next = !addr_hit;
          prdata_next = pwrite ? line_ctrl_pkg::ZERO_WORD : rd_word;
        end
      end
      line_ctrl_pkg::BUS_DONE: begin
        state_next = line_ctrl_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= line_ctrl_pkg::BUS_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= line_ctrl_pkg::ZERO_WORD;
    end else begin
      state_reg <= state_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-line state update
  // Only one register is written per transfer, so each pair resolves alone
  always_comb begin
    cfg_next = cfg_reg;
    wmask_next = wmask_reg;
    if (wr_go) begin
      unique case (paddr)
        line_ctrl_pkg::OFF_LINE_OWNERSHIP_TAKE: begin
          cfg_next.owned = cfg_reg.owned | wdata_lines;
        end
        line_ctrl_pkg::OFF_LINE_RELEASE_TO_PERIPHERAL: begin
          // Lines without a peripheral stay with the controller
          cfg_next.owned = cfg_reg.owned & ~(wdata_lines & MUXED_MASK);
        end
        line_ctrl_pkg::OFF_OUTPUT_DRIVER_ENABLE: begin
          cfg_next.out_en = cfg_reg.out_en | wdata_lines;
        end
        line_ctrl_pkg::OFF_OUTPUT_DRIVER_DISABLE: begin
          cfg_next.out_en = cfg_reg.out_en & ~wdata_lines;
        end
        line_ctrl_pkg::OFF_GLITCH_FILTER_ENABLE: begin
          cfg_next.filt_en = cfg_reg.filt_en | wdata_lines;
        end
        line_ctrl_pkg::OFF_GLITCH_FILTER_DISABLE: begin
          cfg_next.filt_en = cfg_reg.filt_en & ~wdata_lines;
        end
        line_ctrl_pkg::OFF_DRIVE_VALUE_SET: begin
          cfg_next.value = cfg_reg.value | wdata_lines;
        end
        line_ctrl_pkg::OFF_DRIVE_VALUE_CLEAR: begin
          cfg_next.value = cfg_reg.value & ~wdata_lines;
        end
        line_ctrl_pkg::OFF_DRIVE_VALUE_STATUS: begin
          cfg_next.value = (cfg_reg.value & ~wmask_reg) |
                           (wdata_lines & wmask_reg);
        end
        line_ctrl_pkg::OFF_DIRECT_WRITE_MASK_ENABLE: begin
          wmask_next = wmask_reg | wdata_lines;
        end
        line_ctrl_pkg::OFF_DIRECT_WRITE_MASK_DISABLE: begin
          wmask_next = wmask_reg & ~wdata_lines;
        end
        default: begin
          cfg_next = cfg_reg;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_reg.owned <= line_ctrl_pkg::RST_OWNERSHIP & LINE_MASK;
      cfg_reg.out_en <= line_ctrl_pkg::RST_OUT_EN;
      cfg_reg.filt_en <= line_ctrl_pkg::RST_FILT_EN;
      cfg_reg.value <= line_ctrl_pkg::RST_VALUE;
      wmask_reg <= line_ctrl_pkg::RST_WMASK;
    end else begin
      cfg_reg <= cfg_next;
      wmask_reg <= wmask_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign line_cfg = cfg_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_pready_timing: assert property (@(posedge mclk) disable iff (srst)
    (access && !pready) |=> (pready ##1 !pready))
    else $error("pready not a single pulse one cycle after access");

  a_release_line: assert property (@(posedge mclk) disable iff (srst)
    (wr_go && paddr == line_ctrl_pkg::OFF_LINE_RELEASE_TO_PERIPHERAL) |=>
    ((line_cfg.owned & $past(pwdata) & MUXED_MASK & LINE_MASK) == 32'h00000000))
    else $error("released line still owned by controller");

  a_take_line: assert property (@(posedge mclk) disable iff (srst)
    (wr_go && paddr == line_ctrl_pkg::OFF_LINE_OWNERSHIP_TAKE) |=>
    (line_cfg.owned == ($past(line_cfg.owned) | ($past(pwdata) & LINE_MASK))))
    else $error("take write gave wrong ownership");

  a_own_read: assert property (@(posedge mclk) disable iff (srst)
    (pready && !pwrite && paddr == line_ctrl_pkg::OFF_LINE_OWNERSHIP_STATUS) |->
    (prdata == (line_cfg.owned & LINE_MASK) && !pslverr))
    else $error("ownership status read mismatch");

  a_oe_enable: assert property (@(posedge mclk) disable iff (srst)
    (wr_go && paddr == line_ctrl_pkg::OFF_OUTPUT_DRIVER_ENABLE) |=>
    (line_cfg.out_en == ($past(line_cfg.out_en) | ($past(pwdata) & LINE_MASK))))
    else $error("output enable write wrong");

  a_oe_disable: assert property (@(posedge mclk) disable iff (srst)
    (wr_go && paddr == line_ctrl_pkg::OFF_OUTPUT_DRIVER_DISABLE) |=>
    (line_cfg.out_en == ($past(line_cfg.out_en) & ~$past(pwdata))))
    else $error("output disable write wrong");

  a_oe_read: assert property (@(posedge mclk) disable iff (srst)
    (pready && !pwrite && paddr == line_ctrl_pkg::OFF_OUTPUT_DRIVER_STATUS) |->
    prdata == line_cfg.out_en)
    else $error("output status read mismatch");

  a_filt_enable: assert property (@(posedge mclk) disable iff (srst)
    (wr_go && paddr == line_ctrl_pkg::OFF_GLITCH_FILTER_ENABLE) |=>
    (line_cfg.filt_en == ($past(line_cfg.filt_en) | ($past(pwdata) & LINE_MASK))))
    else $error("filter enable write wrong");

  a_filt_disable: assert property (@(posedge mclk) disable iff (srst)
    (wr_go && paddr == line_ctrl_pkg::OFF_GLITCH_FILTER_DISABLE) |=>
    (line_cfg.filt_en == ($past(line_cfg.filt_en) & ~$past(pwdata))))
    else $error("filter disable write wrong");

  a_filt_read: assert property (@(posedge mclk) disable iff (srst)
    (pready && !pwrite && paddr == line_ctrl_pkg::OFF_GLITCH_FILTER_STATUS) |->
    prdata == line_cfg.filt_en)
    else $error("filter status read mismatch");

  a_value_set: assert property (@(posedge mclk) disable iff (srst)
    (wr_go && paddr == line_ctrl_pkg::OFF_DRIVE_VALUE_SET) |=>
    (line_cfg.value == ($past(line_cfg.value) | ($past(pwdata) & LINE_MASK))))
    else $error("set output write wrong");

  a_value_clear: assert property (@(posedge mclk) disable iff (srst)
    (wr_go && paddr == line_ctrl_pkg::OFF_DRIVE_VALUE_CLEAR) |=>
    (line_cfg.value == ($past(line_cfg.value) & ~$past(pwdata))))
    else $error("clear output write wrong");

  a_value_read: assert property (@(posedge mclk) disable iff (srst)
    (pready && !pwrite && paddr == line_ctrl_pkg::OFF_DRIVE_VALUE_STATUS) |->
    prdata == line_cfg.value)
    else $error("drive value read mismatch");

  a_direct_masked: assert property (@(posedge mclk) disable iff (srst)
    (wr_go && paddr == line_ctrl_pkg::OFF_DRIVE_VALUE_STATUS) |=>
    (((line_cfg.value ^ $past(line_cfg.value)) & ~$past(wmask_reg)) == 32'h00000000))
    else $error("direct write changed an unmasked line");

  a_direct_write: assert property (@(posedge mclk) disable iff (srst)
    (wr_go && paddr == line_ctrl_pkg::OFF_DRIVE_VALUE_STATUS) |=>
    (((line_cfg.value ^ $past(pwdata)) & $past(wmask_reg) & LINE_MASK) == 32'h00000000))
    else $error("direct write lost on a writable line");

  a_undef_zero: assert property (@(posedge mclk) disable iff (srst)
    (((line_cfg.owned | line_cfg.out_en | line_cfg.filt_en | line_cfg.value |
       prdata) & ~LINE_MASK) == 32'h00000000))
    else $error("undefined line bit is set");

  a_cfg_hold: assert property (@(posedge mclk) disable iff (srst)
    !wr_go |=> $stable(line_cfg))
    else $error("line state changed without a write");

endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] exp;
  } row_s;

  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  line_ctrl_pkg::line_cfg_s line_cfg;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] bad [4] = '{8'h11, 8'h0C, 8'h3C, 8'hAC};
  // Lines 28..31 undefined, lines 0..7 have no peripheral
  row_s rows [16] = '{
    '{8'h04, 32'hFFFFFFFF, 8'h08, 32'h000000FF},
    '{8'h04, 32'h00000000, 8'h08, 32'h000000FF},
    '{8'h00, 32'h0000FF00, 8'h08, 32'h0000FFFF},
    '{8'h10, 32'h12345678, 8'h18, 32'h02345678},
    '{8'h14, 32'h00000070, 8'h18, 32'h02345608},
    '{8'h14, 32'h00000000, 8'h18, 32'h02345608},
    '{8'h20, 32'hF0F0F0F0, 8'h28, 32'h00F0F0F0},
    '{8'h24, 32'h00F00000, 8'h28, 32'h0000F0F0},
    '{8'h30, 32'h0000FFFF, 8'h38, 32'h0000FFFF},
    '{8'h34, 32'h000000F0, 8'h38, 32'h0000FF0F},
    '{8'h38, 32'hFFFFFFFF, 8'h38, 32'h0000FF0F},
    '{8'hA0, 32'h000000FF, 8'hA8, 32'h000000FF},
    '{8'h38, 32'h00000000, 8'h38, 32'h0000FF00},
    '{8'h38, 32'hFFFFFFFF, 8'h38, 32'h0000FFFF},
    '{8'hA4, 32'h000000F0, 8'hA8, 32'h0000000F},
    '{8'h10, 32'h00000000, 8'h10, 32'h00000000}
  };

  always #12.5 mclk = ~mclk;

  line_ctrl #(.LINE_MASK(32'h0FFFFFFF), .MUXED_MASK(32'hFFFFFF00)) DUT (
    .mclk(mclk),
    .srst(srst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .line_cfg(line_cfg)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hold the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] cfg_field(input logic [7:0] a);
    case (a)
      line_ctrl_pkg::OFF_LINE_OWNERSHIP_STATUS: return line_cfg.owned;
      line_ctrl_pkg::OFF_OUTPUT_DRIVER_STATUS: return line_cfg.out_en;
      line_ctrl_pkg::OFF_GLITCH_FILTER_STATUS: return line_cfg.filt_en;
      line_ctrl_pkg::OFF_DRIVE_VALUE_STATUS: return line_cfg.value;
      default: return 32'h00000000;
    endcase
  endfunction

  task automatic do_reset();
    srst <= 1'b1;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    check("reset owned", line_cfg.owned, 32'h0FFFFFFF);
    check("reset out_en", line_cfg.out_en, 32'h00000000);
    check("reset filt_en", line_cfg.filt_en, 32'h00000000);
    check("reset value", line_cfg.value, 32'h00000000);
    check("reset pready", {31'h0, pready}, 32'h00000000);
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    foreach (rows[i]) begin
      apb(1'b1, rows[i].wa, rows[i].wd);
      check("write err", {31'h0, err}, 32'h00000000);
      check("write rdata", rd, 32'h00000000);
      apb(1'b0, rows[i].ra, 32'h00000000);
      check("read err", {31'h0, err}, 32'h00000000);
      check($sformatf("row %0d status", i), rd, rows[i].exp);
      if (rows[i].ra != 8'h10 && rows[i].ra != 8'hA8) begin
        check($sformatf("row %0d cfg", i), cfg_field(rows[i].ra), rows[i].exp);
      end
    end
    // Status register write is ignored
    apb(1'b1, line_ctrl_pkg::OFF_LINE_OWNERSHIP_STATUS, 32'h00000000);
    check("ro write err", {31'h0, err}, 32'h00000000);
    // The write commits at the edge the task returns on
    @(posedge mclk);
    check("ro write", line_cfg.owned, 32'h0000FFFF);
    // Unaligned and unmapped addresses
    foreach (bad[i]) begin
      apb(1'b1, bad[i], 32'hFFFFFFFF);
      check("bad wr err", {31'h0, err}, 32'h00000001);
      apb(1'b0, bad[i], 32'h00000000);
      check("bad rd err", {31'h0, err}, 32'h00000001);
      check("bad rd data", rd, 32'h00000000);
      check("bad owned", line_cfg.owned, 32'h0000FFFF);
      check("bad out_en", line_cfg.out_en, 32'h02345608);
      check("bad filt_en", line_cfg.filt_en, 32'h0000F0F0);
      check("bad value", line_cfg.value, 32'h0000FFFF);
    end
    // Reset in mid-run, then the direct-write mask is closed again
    do_reset();
    apb(1'b0, line_ctrl_pkg::OFF_DIRECT_WRITE_MASK_STATUS, 32'h00000000);
    check("mask after reset", rd, 32'h00000000);
    apb(1'b1, line_ctrl_pkg::OFF_DRIVE_VALUE_STATUS, 32'hFFFFFFFF);
    apb(1'b0, line_ctrl_pkg::OFF_DRIVE_VALUE_STATUS, 32'h00000000);
    check("masked direct write", rd, 32'h00000000);
    apb(1'b0, line_ctrl_pkg::OFF_LINE_OWNERSHIP_STATUS, 32'h00000000);
    check("ownership after reset", rd, 32'h0FFFFFFF);
    give_verdict();
  end
endmodule
`default_nettype wire
